//--- design/phr_recorder.sv
// Pick hit recorder: label stack, hit detection, record writer.
// Assumes commands and primitives form one ordered stream, never both
// valid in one cycle, each taken only while its ready is high.
// Notes on behaviour
// - clear, pop, push, overwrite on label stack
// - overwrite on empty stack gives error_a
// - pop empty underflows; push full overflows
// - stack holds at least 64 labels
// - three drawing modes; picking blocks framebuffer
// - stack commands outside picking do nothing
// - picking without array, or array during picking
// - clip-intersecting primitive or raster result hits
// - direct window position always hits
// - culled polygons never hit; fill style ignored
// - pending hit writes record before command
// - record: depth, zmin, zmax, labels bottom-up
// - depth bounds span vertices since last record
// - bounds scaled by 2^32-1, rounded
// - no depth offset on stored bounds
// - pointer starts at array base, then advances
// - partial record on overflow, flag set
// - leaving picking returns count, rewinds pointer
// - all record words written before mode completes
// - overflow returns -1 and clears flag
// - every mode command empties label stack
// - hit flag clears; overflow clears entering picking
// - reset selects normal drawing mode
// - leaving reporting returns values written or -1
`timescale 1ns/1ns
module phr_recorder
  import phr_pkg::*;
#(
  parameter int STACK_DEPTH = PHR_STACK_DEPTH,
  parameter int NAME_W = PHR_NAME_W,
  parameter int ADDR_W = PHR_ADDR_W,
  localparam int CW = $clog2(STACK_DEPTH + 1),
  localparam int IW = $clog2(STACK_DEPTH),
  localparam int XW = CW + 1
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire phr_cmd_t cmd_op,
  input wire logic [NAME_W-1:0] cmd_name,
  input wire phr_mode_t cmd_mode,
  input wire logic [ADDR_W-1:0] cmd_base,
  input wire logic [ADDR_W-1:0] cmd_size,
  output logic cmd_ready,
  input wire logic prim_valid,
  input wire phr_prim_t prim_kind,
  input wire logic prim_in_clip,
  input wire logic prim_culled,
  input wire logic raster_valid,
  input wire logic [PHR_Z_W-1:0] prim_zmin,
  input wire logic [PHR_Z_W-1:0] prim_zmax,
  output logic prim_ready,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [NAME_W-1:0] mem_data,
  output logic ret_valid,
  output logic [31:0] ret_value,
  output logic err_valid,
  output phr_err_t err_code,
  output phr_mode_t draw_mode,
  output logic fb_update_en
);

  // ****************************************
  // State
  // ****************************************
  phr_state_t state_q;
  phr_state_t state_d;
  phr_mode_t mode_q;
  logic array_set_q;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] size_q;
  logic [ADDR_W-1:0] off_q;
  logic [ADDR_W-1:0] hits_q;
  logic ovf_q;
  logic hit_q;
  logic [PHR_Z_W-1:0] zmin_q;
  logic [PHR_Z_W-1:0] zmax_q;
  phr_cmd_t pend_op_q;
  logic [NAME_W-1:0] pend_name_q;
  phr_mode_t pend_mode_q;
  logic [XW-1:0] idx_q;
  logic ready_q;
  logic mem_we_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic [NAME_W-1:0] mem_data_q;
  logic ret_valid_q;
  logic [31:0] ret_value_q;
  logic err_valid_q;
  phr_err_t err_code_q;
  logic fb_en_q;

  // ****************************************
  // Decode
  // ****************************************
  logic take;
  logic in_pick;
  logic is_stack;
  logic is_mode;
  phr_err_t cmd_err;
  logic act;
  logic st_empty;
  logic st_full;
  logic [CW-1:0] st_depth;
  logic [NAME_W-1:0] st_rd;
  logic [IW-1:0] st_idx;
  logic st_clr;
  logic st_push;
  logic st_pop;
  logic st_load;
  logic [31:0] zmin_s;
  logic [31:0] zmax_s;
  logic [XW-1:0] rec_last;
  logic [NAME_W-1:0] word;
  logic hit_ev;
  logic applying;

  assign take = cmd_valid && ready_q;
  assign in_pick = (mode_q == PHR_MODE_PICK);
  assign is_stack = (cmd_op == PHR_CMD_CLEAR) || (cmd_op == PHR_CMD_POP) ||
                    (cmd_op == PHR_CMD_PUSH) || (cmd_op == PHR_CMD_LOAD);
  assign is_mode = (cmd_op == PHR_CMD_MODE);
  assign applying = (state_q == PHR_ST_APPLY);

  always_comb
  begin
    cmd_err = PHR_ERR_NONE;
    if (is_stack && in_pick)
    begin
      if (cmd_op == PHR_CMD_LOAD && st_empty)
        cmd_err = PHR_ERR_A;
      else if (cmd_op == PHR_CMD_POP && st_empty)
        cmd_err = PHR_ERR_UNDERFLOW;
      else if (cmd_op == PHR_CMD_PUSH && st_full)
        cmd_err = PHR_ERR_OVERFLOW;
    end
    else if (is_mode && cmd_mode == PHR_MODE_PICK && !in_pick && !array_set_q)
      cmd_err = PHR_ERR_A;
    else if (cmd_op == PHR_CMD_SET_ARRAY && in_pick)
      cmd_err = PHR_ERR_A;
  end

  // Only stack commands in picking mode and mode commands go further
  assign act = take && (cmd_err == PHR_ERR_NONE) && (is_mode || (is_stack && in_pick));

  // ****************************************
  // Sequencer
  // ****************************************
  assign rec_last = XW'(st_depth) + XW'(PHR_REC_HDR - 1);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PHR_ST_IDLE:
        if (act)
          state_d = (in_pick && hit_q) ? PHR_ST_WRITE : PHR_ST_APPLY;
      PHR_ST_WRITE:
        if (idx_q == rec_last)
          state_d = PHR_ST_APPLY;
      PHR_ST_APPLY:
        state_d = PHR_ST_IDLE;
      default:
        state_d = PHR_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q <= PHR_ST_IDLE;
      ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ready_q <= (state_d == PHR_ST_IDLE);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pend_op_q <= PHR_CMD_CLEAR;
      pend_name_q <= '0;
      pend_mode_q <= PHR_MODE_RST;
    end
    else if (act)
    begin
      pend_op_q <= cmd_op;
      pend_name_q <= cmd_name;
      pend_mode_q <= cmd_mode;
    end
  end

  // ****************************************
  // Label stack
  // ****************************************
  // Stack moves only after the record, so the record sees the old labels
  assign st_clr = applying && ((pend_op_q == PHR_CMD_CLEAR) || (pend_op_q == PHR_CMD_MODE));
  assign st_push = applying && (pend_op_q == PHR_CMD_PUSH);
  assign st_pop = applying && (pend_op_q == PHR_CMD_POP);
  assign st_load = applying && (pend_op_q == PHR_CMD_LOAD);
  assign st_idx = IW'(idx_q - XW'(PHR_REC_HDR));

  phr_name_stack #(
    .DEPTH(STACK_DEPTH),
    .W(NAME_W)
  ) u_stack (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clr(st_clr),
    .push(st_push),
    .pop(st_pop),
    .load(st_load),
    .name(pend_name_q),
    .rd_idx(st_idx),
    .rd_data(st_rd),
    .depth(st_depth),
    .empty(st_empty),
    .full(st_full)
  );

  // ****************************************
  // Hit detection and depth bounds
  // ****************************************
  // Fill style never reaches this block; the polygon itself is tested
  assign hit_ev = prim_valid && ready_q && in_pick &&
                  ((prim_kind == PHR_PRIM_WPOS) ||
                   (prim_in_clip && !(prim_kind == PHR_PRIM_POLY && prim_culled) &&
                    (prim_kind != PHR_PRIM_RASTER || raster_valid)));

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      hit_q <= 1'b0;
    else if (applying && (pend_op_q != PHR_CMD_MODE || pend_mode_q == PHR_MODE_PICK))
      hit_q <= 1'b0;
    else if (hit_ev)
      hit_q <= 1'b1;
  end

  // Bounds come in already without depth offset; none is added here
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      zmin_q <= PHR_Z_ONE;
      zmax_q <= '0;
    end
    else if (hit_ev)
    begin
      zmin_q <= (!hit_q || prim_zmin < zmin_q) ? prim_zmin : zmin_q;
      zmax_q <= (!hit_q || prim_zmax > zmax_q) ? prim_zmax : zmax_q;
    end
  end

  phr_depth_scale u_scale_min (
    .z_in(zmin_q),
    .z_scaled(zmin_s)
  );

  phr_depth_scale u_scale_max (
    .z_in(zmax_q),
    .z_scaled(zmax_s)
  );

  // ****************************************
  // Record writer
  // ****************************************
  always_comb
  begin
    case (idx_q)
      XW'(0): word = NAME_W'(st_depth);
      XW'(1): word = zmin_s;
      XW'(2): word = zmax_s;
      default: word = st_rd;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      idx_q <= '0;
    else if (state_q == PHR_ST_WRITE)
      idx_q <= idx_q + XW'(1);
    else
      idx_q <= '0;
  end

  // Writes go straight out, so the array is complete before the return
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mem_we_q <= 1'b0;
      mem_addr_q <= PHR_ADDR_RST;
      mem_data_q <= '0;
    end
    else
    begin
      mem_we_q <= (state_q == PHR_ST_WRITE) && (off_q < size_q);
      mem_addr_q <= base_q + off_q;
      mem_data_q <= word;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      off_q <= '0;
    else if (state_q == PHR_ST_WRITE && off_q < size_q)
      off_q <= off_q + ADDR_W'(1);
    else if (applying && pend_op_q == PHR_CMD_MODE)
      off_q <= '0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ovf_q <= 1'b0;
    else if (state_q == PHR_ST_WRITE && off_q >= size_q)
      ovf_q <= 1'b1;
    else if (applying && pend_op_q == PHR_CMD_MODE)
      ovf_q <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      hits_q <= '0;
    else if (state_q == PHR_ST_WRITE && idx_q == rec_last)
      hits_q <= hits_q + ADDR_W'(1);
    else if (applying && pend_op_q == PHR_CMD_MODE)
      hits_q <= '0;
  end

  // ****************************************
  // Mode and result array
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mode_q <= PHR_MODE_RST;
      fb_en_q <= 1'b1;
    end
    else if (applying && pend_op_q == PHR_CMD_MODE)
    begin
      mode_q <= pend_mode_q;
      fb_en_q <= (pend_mode_q == PHR_MODE_NORMAL);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      array_set_q <= 1'b0;
      base_q <= PHR_ADDR_RST;
      size_q <= '0;
    end
    else if (take && cmd_op == PHR_CMD_SET_ARRAY && cmd_err == PHR_ERR_NONE)
    begin
      array_set_q <= 1'b1;
      base_q <= cmd_base;
      size_q <= cmd_size;
    end
  end

  // ****************************************
  // Return value and errors
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ret_valid_q <= 1'b0;
      ret_value_q <= PHR_RET_NONE;
    end
    else
    begin
      ret_valid_q <= applying && (pend_op_q == PHR_CMD_MODE);
      if (applying && pend_op_q == PHR_CMD_MODE)
      begin
        if (mode_q == PHR_MODE_NORMAL)
          ret_value_q <= PHR_RET_NONE;
        else if (ovf_q)
          ret_value_q <= PHR_RET_OVF;
        else if (mode_q == PHR_MODE_PICK)
          ret_value_q <= 32'(hits_q);
        else
          ret_value_q <= 32'(off_q);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      err_valid_q <= 1'b0;
      err_code_q <= PHR_ERR_NONE;
    end
    else
    begin
      err_valid_q <= take && (cmd_err != PHR_ERR_NONE);
      err_code_q <= take ? cmd_err : PHR_ERR_NONE;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign cmd_ready = ready_q;
  assign prim_ready = ready_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_data = mem_data_q;
  assign ret_valid = ret_valid_q;
  assign ret_value = ret_value_q;
  assign err_valid = err_valid_q;
  assign err_code = err_code_q;
  assign draw_mode = mode_q;
  assign fb_update_en = fb_en_q;

endmodule

//--- shared/phr_pkg.sv
// Shared constants and types for the pick hit recorder.
// Assumes one clock domain and a single ordered command/primitive stream.
package phr_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int PHR_STACK_DEPTH = 64;
  localparam int PHR_NAME_W = 32;
  localparam int PHR_ADDR_W = 32;
  localparam int PHR_Z_W = 33;
  localparam int PHR_REC_HDR = 3;

  // ****************************************
  // Depth format: unsigned 1.32 fixed point
  // ****************************************
  localparam logic [32:0] PHR_Z_ONE = 33'h1_0000_0000;
  localparam logic [32:0] PHR_Z_HALF = 33'h0_8000_0000;

  // ****************************************
  // Return and reset values
  // ****************************************
  localparam logic [31:0] PHR_RET_OVF = 32'hFFFF_FFFF;
  localparam logic [31:0] PHR_RET_NONE = 32'h0000_0000;
  localparam logic [31:0] PHR_ADDR_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    PHR_CMD_CLEAR = 3'h0,
    PHR_CMD_POP = 3'h1,
    PHR_CMD_PUSH = 3'h2,
    PHR_CMD_LOAD = 3'h3,
    PHR_CMD_MODE = 3'h4,
    PHR_CMD_SET_ARRAY = 3'h5
  } phr_cmd_t;

  typedef enum logic [1:0] {
    PHR_MODE_NORMAL = 2'h0,
    PHR_MODE_PICK = 2'h1,
    PHR_MODE_REPORT = 2'h2
  } phr_mode_t;

  localparam phr_mode_t PHR_MODE_RST = PHR_MODE_NORMAL;

  typedef enum logic [1:0] {
    PHR_ERR_NONE = 2'h0,
    PHR_ERR_A = 2'h1,
    PHR_ERR_UNDERFLOW = 2'h2,
    PHR_ERR_OVERFLOW = 2'h3
  } phr_err_t;

  typedef enum logic [2:0] {
    PHR_PRIM_POINT = 3'h0,
    PHR_PRIM_LINE = 3'h1,
    PHR_PRIM_POLY = 3'h2,
    PHR_PRIM_RASTER = 3'h3,
    PHR_PRIM_WPOS = 3'h4
  } phr_prim_t;

  typedef enum logic [2:0] {
    PHR_ST_IDLE = 3'h1,
    PHR_ST_WRITE = 3'h2,
    PHR_ST_APPLY = 3'h4
  } phr_state_t;

endpackage

//--- design/phr_depth_scale.sv
// Depth scaler: unit-range depth to unsigned 32-bit record value.
// Assumes input in 1.32 fixed point; values above one are clamped.
`timescale 1ns/1ns
module phr_depth_scale
  import phr_pkg::*;
(
  input wire logic [PHR_Z_W-1:0] z_in,
  output logic [31:0] z_scaled
);

  logic [PHR_Z_W-1:0] z_clamp;
  logic [PHR_Z_W-1:0] z_diff;

  // z*(2^32-1) = Z - Z/2^32; the second term rounds to 0 or 1
  always_comb
  begin
    z_clamp = (z_in > PHR_Z_ONE) ? PHR_Z_ONE : z_in;
    z_diff = z_clamp - ((z_clamp >= PHR_Z_HALF) ? 33'h0_0000_0001 : 33'h0_0000_0000);
    z_scaled = z_diff[31:0];
  end

endmodule

//--- design/phr_name_stack.sv
// Label stack: storage array with push, pop, overwrite and clear.
// Assumes the caller has already refused illegal operations.
`timescale 1ns/1ns
module phr_name_stack
  import phr_pkg::*;
#(
  parameter int DEPTH = PHR_STACK_DEPTH,
  parameter int W = PHR_NAME_W,
  localparam int CW = $clog2(DEPTH + 1),
  localparam int IW = $clog2(DEPTH)
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic push,
  input wire logic pop,
  input wire logic load,
  input wire logic [W-1:0] name,
  input wire logic [IW-1:0] rd_idx,
  output logic [W-1:0] rd_data,
  output logic [CW-1:0] depth,
  output logic empty,
  output logic full
);

  logic [W-1:0] mem [DEPTH];
  logic [CW-1:0] depth_q;
  logic [CW-1:0] top;

  assign top = depth_q - CW'(1);
  assign empty = (depth_q == '0);
  assign full = (depth_q == CW'(DEPTH));
  assign depth = depth_q;
  assign rd_data = mem[rd_idx];

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      depth_q <= '0;
    else if (clr)
      depth_q <= '0;
    else if (push && !full)
      depth_q <= depth_q + CW'(1);
    else if (pop && !empty)
      depth_q <= top;
  end

  // Storage has no reset; only entries below depth are ever read
  always_ff @(posedge sys_clk)
  begin
    if (push && !full)
      mem[depth_q[IW-1:0]] <= name;
    else if (load && !empty)
      mem[top[IW-1:0]] <= name;
  end

endmodule

//--- verif/phr_recorder_asserts.sv
// Port-level checker for the pick hit recorder.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module phr_recorder_asserts
  import phr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire phr_cmd_t cmd_op,
  input wire logic cmd_ready,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic ret_valid,
  input wire logic err_valid,
  input wire phr_err_t err_code,
  input wire phr_mode_t draw_mode,
  input wire logic fb_update_en
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_fb_only_normal: assert property (fb_update_en == (draw_mode == PHR_MODE_NORMAL))
    else $error("framebuffer enable disagrees with mode");
  a_reset_normal: assert property ($rose(rst_n) |-> draw_mode == PHR_MODE_NORMAL)
    else $error("mode not normal after reset");
  a_err_has_code: assert property (err_valid |-> err_code != PHR_ERR_NONE)
    else $error("error pulse without code");
  a_err_from_cmd: assert property (err_valid |-> $past(cmd_valid) && $past(cmd_ready))
    else $error("error pulse without a taken command");
  a_err_keeps_mode: assert property (err_valid |=> $stable(draw_mode) && !mem_we && !ret_valid)
    else $error("refused command changed the mode or went ahead");
  a_write_in_pick: assert property (mem_we |-> draw_mode == PHR_MODE_PICK)
    else $error("record write outside picking");
  a_write_addr_step: assert property (mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) + 32'h1)
    else $error("record words not consecutive");
  a_mode_answered: assert property (cmd_valid && cmd_ready && cmd_op == PHR_CMD_MODE
    |-> ##[1:70] (ret_valid || err_valid))
    else $error("mode command never answered");
  a_ret_pulse: assert property (ret_valid |=> !ret_valid)
    else $error("return pulse longer than one cycle");
endmodule

bind phr_recorder phr_recorder_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_ready(cmd_ready), .mem_we(mem_we), .mem_addr(mem_addr), .ret_valid(ret_valid),
  .err_valid(err_valid), .err_code(err_code), .draw_mode(draw_mode), .fb_update_en(fb_update_en));

//--- verif/phr_upstream.sv
// Upstream geometry model: issues one command or primitive at a time.
// Assumes its tasks are called from clock-edge context by the bench.
`timescale 1ns/1ns
module phr_upstream
  import phr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic cmd_ready,
  input wire logic prim_ready,
  output logic cmd_valid,
  output phr_cmd_t cmd_op,
  output logic [31:0] cmd_name,
  output phr_mode_t cmd_mode,
  output logic [31:0] cmd_base,
  output logic [31:0] cmd_size,
  output logic prim_valid,
  output phr_prim_t prim_kind,
  output logic prim_in_clip,
  output logic prim_culled,
  output logic raster_valid,
  output logic [32:0] prim_zmin,
  output logic [32:0] prim_zmax,
  output logic hang
);
  initial
  begin
    {cmd_valid, prim_valid, hang} = '0;
    {cmd_name, cmd_base, cmd_size} = '0;
    {prim_in_clip, prim_culled, raster_valid, prim_zmin, prim_zmax} = '0;
    cmd_op = PHR_CMD_CLEAR;
    cmd_mode = PHR_MODE_NORMAL;
    prim_kind = PHR_PRIM_POINT;
  end

  // Bounded wait; a stuck ready flags a hang to the bench
  task automatic wait_rdy(input logic use_prim);
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while ((use_prim ? prim_ready : cmd_ready) !== 1'b1 && n < 100);
    if (n >= 100)
      hang <= 1'b1;
  endtask

  task automatic do_cmd(input phr_cmd_t op, input logic [31:0] a, input logic [31:0] b);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_name <= a;
    cmd_mode <= phr_mode_t'(a[1:0]);
    cmd_base <= a;
    cmd_size <= b;
    wait_rdy(1'b0);
    cmd_valid <= 1'b0;
    // Released name, base and size flip so a stale value is never trusted
    cmd_name <= ~a;
    cmd_base <= ~a;
    cmd_size <= ~b;
    repeat (2) @(posedge sys_clk);
    wait_rdy(1'b0);
    @(posedge sys_clk);
  endtask

  task automatic do_prim(input phr_prim_t k, input logic c, input logic u, input logic r,
    input logic [32:0] zl, input logic [32:0] zh);
    @(posedge sys_clk);
    prim_valid <= 1'b1;
    prim_kind <= k;
    prim_in_clip <= c;
    prim_culled <= u;
    raster_valid <= r;
    prim_zmin <= zl;
    prim_zmax <= zh;
    wait_rdy(1'b1);
    prim_valid <= 1'b0;
    prim_zmin <= ~zl;
    prim_zmax <= ~zh;
    @(posedge sys_clk);
  endtask
endmodule

//--- verif/tb.sv
// Bench for the pick hit recorder: selection sequences and records.
// Assumes the upstream model and the bound checker are compiled first.
`timescale 1ns/1ns
module tb
  import phr_pkg::*;
;
  localparam logic [32:0] Z0 = 33'h0_0000_0000;
  localparam logic [32:0] Z25 = 33'h0_4000_0000;
  localparam logic [32:0] Z75 = 33'h0_C000_0000;
  localparam logic [31:0] S25 = 32'h4000_0000;
  localparam logic [31:0] S75 = 32'hBFFF_FFFF;
  localparam logic [31:0] S1 = 32'hFFFF_FFFF;
  logic sys_clk, rst_n, cmd_valid, cmd_ready, prim_valid, prim_in_clip, prim_culled, raster_valid;
  logic prim_ready, mem_we, ret_valid, err_valid, fb_update_en, hang;
  logic [31:0] cmd_name, cmd_base, cmd_size, mem_addr, mem_data, ret_value, ret_q;
  logic [32:0] prim_zmin, prim_zmax;
  phr_cmd_t cmd_op;
  phr_mode_t cmd_mode, draw_mode;
  phr_prim_t prim_kind;
  phr_err_t err_code, err_q;
  logic [31:0] mem [0:127];
  int comparisons = 0;
  int miscompares = 0;

  phr_recorder #(.STACK_DEPTH(64)) dut_u (.sys_clk, .rst_n, .cmd_valid, .cmd_op, .cmd_name, .cmd_mode,
    .cmd_base, .cmd_size, .cmd_ready, .prim_valid, .prim_kind, .prim_in_clip, .prim_culled, .raster_valid,
    .prim_zmin, .prim_zmax, .prim_ready, .mem_we, .mem_addr, .mem_data, .ret_valid, .ret_value,
    .err_valid, .err_code, .draw_mode, .fb_update_en);
  phr_upstream u_up (.sys_clk, .cmd_ready, .prim_ready, .cmd_valid, .cmd_op, .cmd_name, .cmd_mode,
    .cmd_base, .cmd_size, .prim_valid, .prim_kind, .prim_in_clip, .prim_culled, .raster_valid,
    .prim_zmin, .prim_zmax, .hang);

  // ****************************************
  // Result memory and answer capture
  // ****************************************
  initial
    foreach (mem[i])
      mem[i] = 32'hA5A5_A5A5;
  always @(posedge sys_clk)
  begin
    // A taken command drops old answers, so a missing one shows
    if (cmd_valid && cmd_ready)
    begin
      ret_q <= 32'h5A5A_5A5A;
      err_q <= PHR_ERR_NONE;
    end
    if (mem_we)
      mem[mem_addr[6:0]] <= mem_data;
    if (ret_valid)
      ret_q <= ret_value;
    if (err_valid)
      err_q <= err_code;
    if (hang)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input phr_cmd_t op, input logic [31:0] a, input logic [31:0] b = 32'h0);
    u_up.do_cmd(op, a, b);
  endtask
  task automatic words(input int a, input logic [31:0] q [$]);
    foreach (q[i])
      chk("mem", mem[7'(a + i)], q[i]);
  endtask
  task automatic stop_test();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // Clock and test sequence
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever
      #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    rst_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("draw_mode", draw_mode, PHR_MODE_NORMAL);
    chk("fb_update_en", fb_update_en, 32'h1);
    cmd(PHR_CMD_LOAD, 32'h9);
    chk("err", err_q, PHR_ERR_NONE);
    cmd(PHR_CMD_MODE, 32'h1);
    chk("err", err_q, PHR_ERR_A);
    chk("draw_mode", draw_mode, PHR_MODE_NORMAL);
    $display("test normal_mode done");
    cmd(PHR_CMD_SET_ARRAY, 32'h10, 32'h40);
    cmd(PHR_CMD_MODE, 32'h1);
    chk("ret", ret_q, 32'h0);
    chk("fb_update_en", fb_update_en, 32'h0);
    cmd(PHR_CMD_SET_ARRAY, 32'h60, 32'h4);
    chk("err", err_q, PHR_ERR_A);
    cmd(PHR_CMD_LOAD, 32'h9);
    chk("err", err_q, PHR_ERR_A);
    cmd(PHR_CMD_POP, 32'h0);
    chk("err", err_q, PHR_ERR_UNDERFLOW);
    $display("test errors done");
    cmd(PHR_CMD_PUSH, 32'hA1);
    u_up.do_prim(PHR_PRIM_POINT, 1'b1, 1'b0, 1'b0, Z25, PHR_Z_HALF);
    u_up.do_prim(PHR_PRIM_POLY, 1'b1, 1'b1, 1'b0, Z0, PHR_Z_ONE);
    u_up.do_prim(PHR_PRIM_POINT, 1'b0, 1'b0, 1'b0, Z0, Z0);
    u_up.do_prim(PHR_PRIM_LINE, 1'b1, 1'b0, 1'b0, PHR_Z_HALF, Z75);
    cmd(PHR_CMD_PUSH, 32'hB2);
    u_up.do_prim(PHR_PRIM_WPOS, 1'b0, 1'b0, 1'b0, PHR_Z_ONE, PHR_Z_ONE);
    cmd(PHR_CMD_LOAD, 32'hC3);
    u_up.do_prim(PHR_PRIM_RASTER, 1'b1, 1'b0, 1'b1, Z0, Z0);
    cmd(PHR_CMD_CLEAR, 32'h0);
    u_up.do_prim(PHR_PRIM_POINT, 1'b1, 1'b0, 1'b0, Z0, Z0);
    cmd(PHR_CMD_MODE, 32'h0);
    chk("ret", ret_q, 32'h4);
    words(16, '{32'h1, S25, S75, 32'hA1});
    words(20, '{32'h2, S1, S1, 32'hA1, 32'hB2});
    words(25, '{32'h2, 32'h0, 32'h0, 32'hA1, 32'hC3});
    words(30, '{32'h0, 32'h0, 32'h0});
    $display("test records done");
    cmd(PHR_CMD_MODE, 32'h1);
    u_up.do_prim(PHR_PRIM_RASTER, 1'b1, 1'b0, 1'b0, Z25, Z25);
    cmd(PHR_CMD_POP, 32'h0);
    chk("err", err_q, PHR_ERR_UNDERFLOW);
    u_up.do_prim(PHR_PRIM_POINT, 1'b1, 1'b0, 1'b0, Z0, Z0);
    for (int i = 0; i < 64; i++)
      cmd(PHR_CMD_PUSH, 32'(i));
    words(16, '{32'h0, 32'h0, 32'h0, 32'hA1});
    cmd(PHR_CMD_PUSH, 32'h40);
    chk("err", err_q, PHR_ERR_OVERFLOW);
    cmd(PHR_CMD_MODE, 32'h0);
    chk("ret", ret_q, 32'h1);
    $display("test stack_depth done");
    cmd(PHR_CMD_SET_ARRAY, 32'h40, 32'h4);
    cmd(PHR_CMD_MODE, 32'h1);
    u_up.do_prim(PHR_PRIM_POLY, 1'b1, 1'b0, 1'b0, PHR_Z_ONE, PHR_Z_ONE);
    cmd(PHR_CMD_PUSH, 32'h7);
    u_up.do_prim(PHR_PRIM_WPOS, 1'b0, 1'b0, 1'b0, PHR_Z_ONE, PHR_Z_ONE);
    cmd(PHR_CMD_PUSH, 32'h8);
    cmd(PHR_CMD_MODE, 32'h0);
    chk("ret", ret_q, PHR_RET_OVF);
    words(64, '{32'h0, S1, S1, 32'h1, 32'hA5A5_A5A5});
    cmd(PHR_CMD_MODE, 32'h1);
    cmd(PHR_CMD_MODE, 32'h0);
    chk("ret", ret_q, 32'h0);
    cmd(PHR_CMD_MODE, 32'h2);
    chk("draw_mode", draw_mode, PHR_MODE_REPORT);
    cmd(PHR_CMD_MODE, 32'h0);
    chk("ret", ret_q, 32'h0);
    $display("test overflow done");
    stop_test();
  end
endmodule
